// ---- rtl/acu_bcd_conv.sv ----
// Purpose: signed 32-bit binary to seven-digit sign-filled BCD word
// Assumes: purely combinational, result used only when in_range is high
// Notes:   magnitude fits 24 bits whenever the value is in range
`timescale 1ns/10ps
module acu_bcd_conv (
   // operand
   input  wire logic [31:0] bin_in,
   // result
   output logic      [31:0] bcd_out,
   output logic             in_range
);
   import acu_pkg::*;

   logic [31:0] mag;      // absolute value, -2^31 gives 2^31
   logic [27:0] digits;   // seven packed digits

   // shift-and-add-three over the low 24 magnitude bits
   function automatic logic [27:0] dabble(input logic [23:0] v);
      logic [27:0] d;
      d = 28'h0;
      for (int i = 23; i >= 0; i--) begin
         for (int k = 0; k < 7; k++) begin
            if (d[4*k +: 4] > 4'h4) begin
               d[4*k +: 4] = d[4*k +: 4] + 4'h3;
            end
         end
         d = {d[26:0], v[i]};
      end
      return d;
   endfunction : dabble

   // magnitude, range check and sign fill
   always_comb begin
      mag      = bin_in[31] ? (~bin_in + 32'h1) : bin_in;
      in_range = (mag <= ACU_BCD_MAX);
      digits   = dabble(mag[23:0]);
      bcd_out  = {{4{bin_in[31]}}, digits};  // [RULE_02] [RULE_03]
   end
endmodule : acu_bcd_conv

// ---- rtl/acu_int_to_float.sv ----
// Purpose: signed 32-bit integer to single-precision float
// Assumes: purely combinational
// Notes:   round to nearest, ties to even mantissa
`timescale 1ns/10ps
module acu_int_to_float (
   // operand
   input  wire logic [31:0] int_in,
   // result
   output logic      [31:0] flt_out
);
   import acu_pkg::*;

   logic [31:0] mag;      // absolute value
   logic [31:0] norm;     // magnitude with leading one at bit 31
   logic [4:0]  lz;       // leading zero count
   logic [30:0] packed_v; // exponent and mantissa before rounding
   logic        rnd_up;   // round increment

   // normalise, then round on guard and sticky bits
   always_comb begin
      mag = int_in[31] ? (~int_in + 32'h1) : int_in;
      lz  = 5'd0;
      for (int i = 0; i < 32; i++) begin
         if (mag[i]) begin
            lz = 5'(31 - i);
         end
      end
      norm     = mag << lz;
      packed_v = {ACU_FLT_BIAS31 - {3'b000, lz}, norm[30:8]};
      rnd_up   = norm[7] & ((|norm[6:0]) | norm[8]);  // [RULE_14]
      if (mag == 32'h0) begin
         flt_out = 32'h0;
      end else begin
         // carry out of the mantissa bumps the exponent [RULE_05]
         flt_out = {int_in[31], packed_v + {30'h0, rnd_up}};
      end
   end
endmodule : acu_int_to_float

// ---- rtl/acu_pkg.sv ----
// Purpose: shared constants and types for the accumulator conversion unit
// Assumes: 32-bit Avalon-MM slave with byte addresses, one aligned word per register
// Notes:   every offset, field position and reset value is named here once
package acu_pkg;
   // register byte offsets
   localparam logic [4:0] ACU_OFS_ACC1    = 5'h00;  // primary accumulator
   localparam logic [4:0] ACU_OFS_ACC2    = 5'h04;  // secondary accumulator
   localparam logic [4:0] ACU_OFS_STATUS  = 5'h08;  // status word
   localparam logic [4:0] ACU_OFS_CMD     = 5'h0c;  // operation issue, write only
   localparam logic [4:0] ACU_OFS_IRQ_STS = 5'h10;  // sticky events, read only
   localparam logic [4:0] ACU_OFS_IRQ_CLR = 5'h14;  // event clear, write only
   localparam logic [4:0] ACU_OFS_IRQ_EN  = 5'h18;  // event enable
   // status word bit positions
   localparam int ACU_ST_RLO_POS = 0;    // logic result bit
   localparam int ACU_ST_OS_POS  = 1;    // sticky fault flag
   localparam int ACU_ST_OV_POS  = 2;    // arith fault flag
   localparam int ACU_ST_CC0_POS = 3;    // cond code lo
   localparam int ACU_ST_CC1_POS = 4;    // cond code hi
   // event bit positions
   localparam int ACU_EV_DONE_POS  = 0;  // operation finished
   localparam int ACU_EV_FAULT_POS = 1;  // operation raised the fault flag
   localparam int ACU_EV_W         = 2;  // number of event bits
   // reset values
   localparam logic [31:0] ACU_ACC_RST    = 32'h0000_0000;
   localparam logic [4:0]  ACU_STATUS_RST = 5'h00;
   localparam logic [1:0]  ACU_EV_RST     = 2'h0;
   // conversion constants
   localparam logic [31:0] ACU_BCD_MAX    = 32'h0098_967f;  // 9,999,999
   localparam logic [15:0] ACU_MIN16      = 16'h8000;       // -32768
   localparam logic [31:0] ACU_MIN32      = 32'h8000_0000;  // most negative
   localparam logic [7:0]  ACU_FLT_BIAS31 = 8'h9e;          // exponent bias 127 + 31
   // condition code pairs
   localparam logic [1:0] ACU_CC_ZERO = 2'b00;
   localparam logic [1:0] ACU_CC_NEG  = 2'b01;
   localparam logic [1:0] ACU_CC_POS  = 2'b10;

   // operation codes written to the command register
   typedef enum logic [3:0] {
      ACU_OP_NOP      = 4'b0000,
      ACU_OP_SEXT     = 4'b0001,  // sext_16_to_32_op
      ACU_OP_BCD      = 4'b0010,  // bin32_to_bcd_op
      ACU_OP_I2F      = 4'b0011,  // integer to float
      ACU_OP_NOT16    = 4'b0100,  // not16_op
      ACU_OP_NOT32    = 4'b0101,  // not32_op
      ACU_OP_NEG16    = 4'b0110,  // neg16_op
      ACU_OP_NEG32    = 4'b0111,  // neg32_op
      ACU_OP_FSIGN    = 4'b1000   // float_sign_flip_op
   } acu_op_type;

   // status word as carried between processes
   typedef struct packed {
      logic cond_code_hi;
      logic cond_code_lo;
      logic arith_fault_flag;
      logic sticky_fault_flag;
      logic logic_result_bit;
   } acu_status_type;

   // bus handshake states
   typedef enum logic {
      ACU_BUS_IDLE = 1'b0,
      ACU_BUS_ACK  = 1'b1
   } acu_bus_type;
endpackage : acu_pkg

// ---- rtl/acu_top.sv ----
// Purpose: accumulator conversion and complement unit behind an Avalon-MM slave
// Assumes: single clock, asynchronous active-low reset, one operation per command write
// Notes:   an operation takes effect at the edge that completes its command write
//
// Behaviour
// [RULE_01] sign-extend low word into whole accumulator
// [RULE_02] binary to seven BCD digits in bits 0-27
// [RULE_03] bits 28-31 filled with the sign
// [RULE_04] BCD out of range sets both fault flags
// [RULE_05] integer to float, other status untouched
// [RULE_06] invert low word only, status untouched
// [RULE_07] invert whole accumulator, status untouched
// [RULE_08] low word negated by invert plus one
// [RULE_09] 16-bit negation codes, fault on -32768
// [RULE_10] whole accumulator negated by invert plus one
// [RULE_11] 32-bit negation codes, fault on minimum
// [RULE_12] 32-bit negation leaves logic result bit
// [RULE_13] float negation flips bit 31 only
// [RULE_14] float rounding nearest, ties to even
// [RULE_15] 16-bit ops keep high word and secondary
// [RULE_16] BCD out of range keeps the accumulator
`timescale 1ns/10ps
module acu_top #(
   parameter int DATA_W = 32  // accumulator width, only 32 is served
) (
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 nrst,
   // avalon-mm slave
   input  wire logic [4:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [DATA_W-1:0]    avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output logic      [DATA_W-1:0]    avs_readdata,
   output logic                      avs_waitrequest,
   // interrupt
   output logic                      irq
);
   import acu_pkg::*;

   // the datapath is written for a 32-bit word
   if (DATA_W != 32) begin : g_bad_width
      $error("acu_top supports DATA_W of 32 only");
   end

   acu_bus_type    bus_ff;          // handshake state
   logic [31:0]    acc1_ff;         // primary accumulator
   logic [31:0]    acc2_ff;         // secondary accumulator
   acu_status_type st_ff;           // status word
   logic [1:0]     ev_sts_ff;       // sticky events
   logic [1:0]     ev_en_ff;        // event enables
   logic [31:0]    rdata_ff;        // registered read data
   logic           wait_ff;         // registered waitrequest
   logic           irq_ff;          // registered interrupt

   logic           wr_go;           // write completes this edge
   logic [31:0]    wmask;           // byte lane mask
   logic           cmd_go;          // operation issued this edge
   acu_op_type     op;              // decoded operation
   logic [31:0]    nxt_acc1;        // datapath result
   acu_status_type nxt_st;          // datapath status
   logic           op_fault;        // operation raised arith fault
   logic [31:0]    bcd_word;        // converter result
   logic           bcd_ok;          // converter input in range
   logic [31:0]    flt_word;        // float converter result
   logic [15:0]    neg16;           // negated low word
   logic [31:0]    neg32;           // negated whole word
   logic [1:0]     ev_set;          // events this edge
   logic [1:0]     ev_clr;          // clears this edge
   logic [31:0]    rd_mux;          // read selection

   // byte enables widened to a bit mask
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      logic [31:0] m;
      m = 32'h0;
      for (int b = 0; b < 4; b++) begin
         m[8*b +: 8] = {8{be[b]}};
      end
      return m;
   endfunction : lane_mask

   // condition codes and fault after a negation, sticky kept unless faulting
   function automatic acu_status_type neg_status(input acu_status_type s,
                                                 input logic is_zero,
                                                 input logic is_neg,
                                                 input logic is_min);
      acu_status_type r;
      r = s;
      if (is_min) begin
         {r.cond_code_hi, r.cond_code_lo} = ACU_CC_NEG;
         r.arith_fault_flag  = 1'b1;
         r.sticky_fault_flag = 1'b1;
      end else begin
         if (is_zero) begin
            {r.cond_code_hi, r.cond_code_lo} = ACU_CC_ZERO;
         end else if (is_neg) begin
            {r.cond_code_hi, r.cond_code_lo} = ACU_CC_NEG;
         end else begin
            {r.cond_code_hi, r.cond_code_lo} = ACU_CC_POS;
         end
         r.arith_fault_flag = 1'b0;
      end
      return r;
   endfunction : neg_status

   // converters
   acu_bcd_conv u_bcd (
      .bin_in   (acc1_ff),
      .bcd_out  (bcd_word),
      .in_range (bcd_ok)
   );

   acu_int_to_float u_i2f (
      .int_in  (acc1_ff),
      .flt_out (flt_word)
   );

   // request decode
   assign wr_go  = (bus_ff == ACU_BUS_ACK) && avs_write;
   assign wmask  = lane_mask(avs_byteenable);
   assign cmd_go = wr_go && (avs_address == ACU_OFS_CMD) && avs_byteenable[0];
   assign op     = acu_op_type'(avs_writedata[3:0]);
   assign neg16  = ~acc1_ff[15:0] + 16'h1;
   assign neg32  = ~acc1_ff + 32'h1;

   // operation datapath
   always_comb begin
      nxt_acc1 = acc1_ff;
      nxt_st   = st_ff;
      op_fault = 1'b0;
      case (op)
         ACU_OP_SEXT: begin
            nxt_acc1 = {{16{acc1_ff[15]}}, acc1_ff[15:0]};  // [RULE_01]
         end
         ACU_OP_BCD: begin
            if (bcd_ok) begin
               nxt_acc1 = bcd_word;  // [RULE_02] [RULE_03]
            end else begin
               // accumulator kept, only the two fault flags rise [RULE_04] [RULE_16]
               nxt_st.arith_fault_flag  = 1'b1;
               nxt_st.sticky_fault_flag = 1'b1;
               op_fault                 = 1'b1;
            end
         end
         ACU_OP_I2F: begin
            nxt_acc1 = flt_word;  // [RULE_05]
         end
         ACU_OP_NOT16: begin
            nxt_acc1 = {acc1_ff[31:16], ~acc1_ff[15:0]};  // [RULE_06] [RULE_15]
         end
         ACU_OP_NOT32: begin
            nxt_acc1 = ~acc1_ff;  // [RULE_07]
         end
         ACU_OP_NEG16: begin
            nxt_acc1 = {acc1_ff[31:16], neg16};  // [RULE_08] [RULE_15]
            nxt_st   = neg_status(st_ff, neg16 == 16'h0, neg16[15],
                                  acc1_ff[15:0] == ACU_MIN16);  // [RULE_09]
            op_fault = (acc1_ff[15:0] == ACU_MIN16);
         end
         ACU_OP_NEG32: begin
            nxt_acc1 = neg32;  // [RULE_10]
            // logic result bit passes through neg_status untouched [RULE_12]
            nxt_st   = neg_status(st_ff, neg32 == 32'h0, neg32[31],
                                  acc1_ff == ACU_MIN32);  // [RULE_11]
            op_fault = (acc1_ff == ACU_MIN32);
         end
         ACU_OP_FSIGN: begin
            nxt_acc1 = {~acc1_ff[31], acc1_ff[30:0]};  // [RULE_13]
         end
         default: begin
            nxt_acc1 = acc1_ff;  // no-op and unknown codes change nothing
         end
      endcase
   end

   // bus handshake: one wait cycle, then the transfer completes
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bus_ff  <= ACU_BUS_IDLE;
         wait_ff <= 1'b1;
      end else begin
         case (bus_ff)
            ACU_BUS_IDLE: begin
               if (avs_read || avs_write) begin
                  bus_ff  <= ACU_BUS_ACK;
                  wait_ff <= 1'b0;
               end
            end
            ACU_BUS_ACK: begin
               bus_ff  <= ACU_BUS_IDLE;
               wait_ff <= 1'b1;
            end
            default: begin
               bus_ff  <= ACU_BUS_IDLE;
               wait_ff <= 1'b1;
            end
         endcase
      end
   end

   // read selection, unmapped and write-only offsets read zero
   always_comb begin
      case (avs_address)
         ACU_OFS_ACC1:    rd_mux = acc1_ff;
         ACU_OFS_ACC2:    rd_mux = acc2_ff;
         ACU_OFS_STATUS:  rd_mux = {27'h0, st_ff};
         ACU_OFS_IRQ_STS: rd_mux = {30'h0, ev_sts_ff};
         ACU_OFS_IRQ_EN:  rd_mux = {30'h0, ev_en_ff};
         default:         rd_mux = 32'h0;
      endcase
   end

   // read data captured as the wait cycle ends
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdata_ff <= 32'h0;
      end else if (bus_ff == ACU_BUS_IDLE && avs_read) begin
         rdata_ff <= rd_mux;
      end
   end

   // primary accumulator: software write or operation result
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         acc1_ff <= ACU_ACC_RST;
      end else if (cmd_go) begin
         acc1_ff <= nxt_acc1;
      end else if (wr_go && avs_address == ACU_OFS_ACC1) begin
         acc1_ff <= (acc1_ff & ~wmask) | (avs_writedata & wmask);
      end
   end

   // secondary accumulator: only software writes it [RULE_15]
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         acc2_ff <= ACU_ACC_RST;
      end else if (wr_go && avs_address == ACU_OFS_ACC2) begin
         acc2_ff <= (acc2_ff & ~wmask) | (avs_writedata & wmask);
      end
   end

   // status word: operation result or low-byte software write
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st_ff <= acu_status_type'(ACU_STATUS_RST);
      end else if (cmd_go) begin
         st_ff <= nxt_st;
      end else if (wr_go && avs_address == ACU_OFS_STATUS && avs_byteenable[0]) begin
         st_ff <= acu_status_type'(avs_writedata[4:0]);
      end
   end

   // event sources and clears
   always_comb begin
      ev_set                   = 2'h0;
      ev_set[ACU_EV_DONE_POS]  = cmd_go;
      ev_set[ACU_EV_FAULT_POS] = cmd_go && op_fault;
      ev_clr                   = 2'h0;
      if (wr_go && avs_address == ACU_OFS_IRQ_CLR && avs_byteenable[0]) begin
         ev_clr = avs_writedata[1:0];
      end
   end

   // sticky events, a set in the clearing cycle wins
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ev_sts_ff <= ACU_EV_RST;
      end else begin
         ev_sts_ff <= (ev_sts_ff & ~ev_clr) | ev_set;
      end
   end

   // event enables
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ev_en_ff <= ACU_EV_RST;
      end else if (wr_go && avs_address == ACU_OFS_IRQ_EN && avs_byteenable[0]) begin
         ev_en_ff <= avs_writedata[1:0];
      end
   end

   // interrupt level follows enabled sticky events one edge later
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(ev_sts_ff & ev_en_ff);
      end
   end

   // outputs straight from flip-flops
   assign avs_readdata    = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign irq             = irq_ff;
endmodule : acu_top

// ---- sim/acu_monitor.sv ----
// Purpose: bus and result checks for the conversion unit
// Assumes: results judged on acc1 write, one cmd write, then acc1 read
// Notes:   shadow follows every acc1 write, valid only after a full-lane one
`timescale 1ns/10ps
module acu_monitor
   import acu_pkg::*;
(
   // clock and reset
   input wire logic        clock,
   input wire logic        nrst,
   // avalon-mm slave
   input wire logic [4:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   logic [31:0] sh_ff;   // operand last written to acc1
   logic [3:0]  op_ff;   // op issued since then
   logic        val_ff;  // shadow still describes acc1
   logic        wr_end;  // write completes this edge
   logic        rd_acc;  // acc1 read completes this edge
   logic        in_rng;  // bcd operand in range
   assign wr_end = avs_write && !avs_waitrequest;
   assign rd_acc = val_ff && avs_read && !avs_waitrequest && avs_address == ACU_OFS_ACC1;
   assign in_rng = $signed(sh_ff) <= 32'sd9999999 && $signed(sh_ff) >= -32'sd9999999;
   // shadow of operand and op, one real op at most
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sh_ff  <= '0;
         op_ff  <= '0;
         val_ff <= 1'b0;
      end else if (wr_end && avs_address == ACU_OFS_ACC1) begin
         sh_ff  <= avs_writedata;
         op_ff  <= ACU_OP_NOP;
         val_ff <= (avs_byteenable == 4'hf);
      end else if (wr_end && avs_address == ACU_OFS_CMD) begin
         op_ff  <= avs_writedata[3:0];
         val_ff <= val_ff && (op_ff == ACU_OP_NOP);
      end
   end
   property p_wait_one;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait low too long");
   property p_wait_ans;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_ans: assert property (p_wait_ans) else $error("no answer");
   property p_sext;
      rd_acc && op_ff == ACU_OP_SEXT |-> avs_readdata == {{16{sh_ff[15]}}, sh_ff[15:0]};
   endproperty
   a_sext: assert property (p_sext) else $error("sign extend");
   property p_bcd;
      rd_acc && op_ff == ACU_OP_BCD |->
         (in_rng ? avs_readdata[31:28] == {4{sh_ff[31]}} : avs_readdata == sh_ff);
   endproperty
   a_bcd: assert property (p_bcd) else $error("bcd word");
   property p_not16;
      rd_acc && op_ff == ACU_OP_NOT16 |-> avs_readdata == {sh_ff[31:16], ~sh_ff[15:0]};
   endproperty
   a_not16: assert property (p_not16) else $error("invert low");
   property p_not32;
      rd_acc && op_ff == ACU_OP_NOT32 |-> avs_readdata == ~sh_ff;
   endproperty
   a_not32: assert property (p_not32) else $error("invert all");
   property p_neg16;
      rd_acc && op_ff == ACU_OP_NEG16 |->
         avs_readdata == {sh_ff[31:16], 16'h0 - sh_ff[15:0]};
   endproperty
   a_neg16: assert property (p_neg16) else $error("negate low");
   property p_neg32;
      rd_acc && op_ff == ACU_OP_NEG32 |-> avs_readdata == 32'h0 - sh_ff;
   endproperty
   a_neg32: assert property (p_neg32) else $error("negate all");
   property p_fsign;
      rd_acc && op_ff == ACU_OP_FSIGN |-> avs_readdata == {~sh_ff[31], sh_ff[30:0]};
   endproperty
   a_fsign: assert property (p_fsign) else $error("sign flip");
   property p_unmap;
      avs_read && !avs_waitrequest && avs_address == 5'h1c |-> avs_readdata == '0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule : acu_monitor

// ---- sim/acu_seq_model.sv ----
// Purpose: sequencer model issuing register cycles to the unit
// Assumes: one transfer at a time, signals change just after an edge
// Notes:   released write data is inverted so stale data never passes
`timescale 1ns/10ps
module acu_seq_model (
   // clock
   input  wire logic        clock,
   // avalon-mm master side
   output logic      [4:0]  avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic      [31:0] avs_writedata,
   output logic      [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   // idle bus at time zero
   initial begin
      avs_address    = '0;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = '0;
      avs_byteenable = 4'hf;
   end
   // write held until waitrequest sampled low
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
      @(posedge clock);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_write      <= 1'b1;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      avs_write      <= 1'b0;
      avs_writedata  <= ~d;
   endtask : wr
   // read data taken at the completing edge
   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_read    <= 1'b1;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read    <= 1'b0;
   endtask : rd
endmodule : acu_seq_model

// ---- sim/tb_acu_top.sv ----
// Purpose: self-checking bench for the conversion unit
// Assumes: status word bits {cc hi, cc lo, fault, sticky, logic result}
// Notes:   each case loads status and operand, issues one op, reads back
`timescale 1ns/10ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; $display("unexpected at %0t got %h exp %h", $time, (got), (exp)); end end
module tb_acu_top;
   import acu_pkg::*;
   typedef struct packed {
      logic [3:0]  op;    // opcode
      logic [31:0] opnd;  // acc1 before
      logic [4:0]  st0;   // status before
      logic [31:0] res;   // acc1 after
      logic [4:0]  st1;   // status after
   } acu_case_type;
   localparam int NC = 25;  // number of cases
   localparam acu_case_type TBL [NC] = '{
      '{4'h1, 32'h1234fff6, 5'h15, 32'hfffffff6, 5'h15}, '{4'h1, 32'hffff7fff, 5'h00, 32'h00007fff, 5'h00},
      '{4'h2, 32'h0098967f, 5'h00, 32'h09999999, 5'h00}, '{4'h2, 32'hff676981, 5'h09, 32'hf9999999, 5'h09},
      '{4'h2, 32'h0012d687, 5'h00, 32'h01234567, 5'h00}, '{4'h2, 32'h00989680, 5'h11, 32'h00989680, 5'h17},
      '{4'h2, 32'hff676980, 5'h08, 32'hff676980, 5'h0e}, '{4'h3, 32'h00000001, 5'h1f, 32'h3f800000, 5'h1f},
      '{4'h3, 32'h01000001, 5'h00, 32'h4b800000, 5'h00}, '{4'h3, 32'h01000003, 5'h00, 32'h4b800002, 5'h00},
      '{4'h3, 32'h80000000, 5'h00, 32'hcf000000, 5'h00}, '{4'h3, 32'hffffffff, 5'h00, 32'hbf800000, 5'h00},
      '{4'h4, 32'habcd63ae, 5'h06, 32'habcd9c51, 5'h06}, '{4'h5, 32'h6f8c63ae, 5'h06, 32'h90739c51, 5'h06},
      '{4'h6, 32'h12345d38, 5'h07, 32'h1234a2c8, 5'h0b}, '{4'h6, 32'hffff0000, 5'h14, 32'hffff0000, 5'h00},
      '{4'h6, 32'h0000ffff, 5'h00, 32'h00000001, 5'h10}, '{4'h6, 32'habcd8000, 5'h00, 32'habcd8000, 5'h0e},
      '{4'h7, 32'h5f645d38, 5'h01, 32'ha09ba2c8, 5'h09}, '{4'h7, 32'h80000000, 5'h00, 32'h80000000, 5'h0e},
      '{4'h7, 32'h00000000, 5'h15, 32'h00000000, 5'h01}, '{4'h7, 32'hffffffff, 5'h03, 32'h00000001, 5'h13},
      '{4'h8, 32'h43160000, 5'h1f, 32'hc3160000, 5'h1f}, '{4'h0, 32'h5a5a5a5a, 5'h0a, 32'h5a5a5a5a, 5'h0a},
      '{4'hf, 32'h12345678, 5'h00, 32'h12345678, 5'h00}};
   logic        clock;            // 100 MHz
   logic        nrst;             // async reset, low
   logic [4:0]  avs_address;      // bus from model
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;     // bus from unit
   logic        avs_waitrequest;
   logic        irq;
   logic [31:0] rdat;             // last read value
   int          n_errors;
   int          checks;
   int          cycles;           // watchdog count
   acu_top dut (.clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
   acu_seq_model seq (.clock(clock), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   // clock
   initial clock = 1'b0;
   always #5 clock = ~clock;
   // counts and verdict, ends the run
   task give_verdict;
      $display("comparisons %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict
   // watchdog against a hung handshake
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         give_verdict();
      end
   end
   // main sequence
   initial begin
      nrst = 1'b0;
      n_errors = 0;
      checks = 0;
      cycles = 0;
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      seq.rd(ACU_OFS_ACC1, rdat);
      `CHK(rdat, ACU_ACC_RST)
      seq.rd(ACU_OFS_STATUS, rdat);
      `CHK(rdat[4:0], ACU_STATUS_RST)
      `CHK(irq, 1'b0)
      $display("test reset done");
      // refused places and byte lanes
      seq.wr(5'h1c, 32'hffffffff);
      seq.rd(5'h1c, rdat);
      `CHK(rdat, 32'h0)
      seq.wr(ACU_OFS_IRQ_STS, 32'h3);
      seq.rd(ACU_OFS_IRQ_STS, rdat);
      `CHK(rdat, 32'h0)
      seq.wr(ACU_OFS_ACC1, 32'h11223344);
      seq.wr(ACU_OFS_ACC1, 32'haabbccdd, 4'h5);
      seq.rd(ACU_OFS_ACC1, rdat);
      `CHK(rdat, 32'h11bb33dd)
      $display("test bus done");
      // every op from the table
      seq.wr(ACU_OFS_ACC2, 32'h5aa5c33c);
      foreach (TBL[i]) begin
         seq.wr(ACU_OFS_STATUS, {27'h0, TBL[i].st0});
         seq.wr(ACU_OFS_ACC1, TBL[i].opnd);
         seq.wr(ACU_OFS_CMD, {28'h0, TBL[i].op});
         seq.rd(ACU_OFS_ACC1, rdat);
         `CHK(rdat, TBL[i].res)
         seq.rd(ACU_OFS_STATUS, rdat);
         `CHK(rdat[4:0], TBL[i].st1)
      end
      seq.rd(ACU_OFS_ACC2, rdat);
      `CHK(rdat, 32'h5aa5c33c)
      seq.rd(ACU_OFS_CMD, rdat);
      `CHK(rdat, 32'h0)
      $display("test ops done");
      // events: raise, mask, clear
      seq.rd(ACU_OFS_IRQ_STS, rdat);
      `CHK(rdat, 32'h3)
      `CHK(irq, 1'b0)
      seq.wr(ACU_OFS_IRQ_EN, 32'h2);
      seq.rd(ACU_OFS_IRQ_EN, rdat);
      `CHK(rdat, 32'h2)
      `CHK(irq, 1'b1)
      seq.wr(ACU_OFS_IRQ_CLR, 32'h2);
      seq.rd(ACU_OFS_IRQ_STS, rdat);
      `CHK(rdat, 32'h1)
      `CHK(irq, 1'b0)
      seq.wr(ACU_OFS_IRQ_EN, 32'h3);
      seq.rd(ACU_OFS_IRQ_EN, rdat);
      `CHK(irq, 1'b1)
      seq.wr(ACU_OFS_IRQ_CLR, 32'h3);
      seq.rd(ACU_OFS_IRQ_STS, rdat);
      `CHK(rdat, 32'h0)
      `CHK(irq, 1'b0)
      $display("test irq done");
      give_verdict();
   end
endmodule : tb_acu_top
bind acu_top acu_monitor mon (.clock(clock), .nrst(nrst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .irq(irq));
